// File: idle_release_and_reset_gen.sv
// Sleep release, reset generation and core flag registers
// Contract
// - Enabled interrupt with master off resumes, no vector
// - Enabled interrupt with master on wakes and vectors
// - Reset pin in sleep resets, restarts running
// - Watchdog interrupt before sleep entry cancels sleep
// - Reset from pin, trap, watchdog or clock guard
// - Reset causes cleared by power-on, not by internal reset
// - Reset clears bank, enables, nesting, prescaler, divider
// - Reset sets jump flag, enables watchdog, keeps rest
// - Pin low three machine cycles initialises device
// - Pin release fetches reset vector then runs
// - Permitted trap resets on fetch from data areas
// - Trap permitted after reset, changed by key
// - Prohibited trap lets RAM fetches execute
// - Trap control and key registers write-only
// - Software trap next address inside area traps
// - Clock guard bit writes raise internal reset
// - Sleep stops core and watchdog, peripherals run
// - Sleep entered by sleep-request bit write
// - Machine cycle is four clock states
// - Pending latch set by request, cleared on accept
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/100ps
`include "idle_reset_regs.svh"
module idle_release_and_reset_gen #(
  parameter int N_SRC = 8,
  parameter int ADDR_W = 8,
  parameter logic [19:0] RAM_LO = 20'h0_0040,
  parameter logic [19:0] RAM_HI = 20'h0_02BF,
  parameter logic [19:0] DBR_LO = 20'h0_0F00,
  parameter logic [19:0] DBR_HI = 20'h0_0FFF
) (
  input wire logic ref_clk,
  input wire logic resetn,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // External reset pin, raw
  input wire logic reset_pin_n,
  // Core fetch and interrupt side
  input wire logic fetch_valid,
  input wire logic [19:0] fetch_addr,
  input wire logic swi_exec,
  input wire logic [N_SRC-1:0] irq_request,
  input wire logic wdt_reset,
  output logic core_reset_n,
  output logic core_run,
  output logic periph_run,
  output logic wdt_run,
  output logic irq_accept,
  output logic [4:0] irq_accept_id,
  output logic wake_resume,
  output logic vector_fetch,
  output logic [19:0] vector_addr,
  output logic [3:0] bank_selector,
  output logic master_irq_enable,
  output logic nesting_flag,
  output logic jump_status_flag,
  output logic [1:0] mc_state,
  output logic [20:0] div_out
);

  // State of the block, divider and reset combiner apart
  typedef struct packed {
    logic aw_v;
    logic [ADDR_W-1:0] aw_a;
    logic w_v;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    idle_reset_pkg::mode_type mode;
    logic idle_req;
    logic [7:0] sys2;
    logic [7:0] core;
    logic [N_SRC-1:0] en;
    logic [N_SRC-1:0] pend;
    logic trap_allowed;
    logic key_armed;
    logic [3:0] cause;
    logic accept;
    logic [4:0] accept_id;
    logic resume;
    logic rst_d;
    logic vec;
  } state_type;

  state_type s_r;
  state_type s_nxt;

  logic rst_int; // Internal reset level
  logic pin_low; // Synchronised pin level
  logic mc_tick; // Last state of a machine cycle
  logic trap_hit; // Fetch into a forbidden area
  logic guard_hit; // Clock guard write seen
  logic [N_SRC-1:0] en_eff; // Enables, watchdog source always on
  logic [N_SRC-1:0] wake_set; // Pending and enabled sources
  logic [19:0] chk_addr; // Address examined for the trap

  // Byte lane merge of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[8*i +: 8] = dat[8*i +: 8];
    end
    return r;
  endfunction

  // Machine cycle timing, cleared by internal reset
  machine_cycle_gen #(
    .PRE_W(3),
    .DIV_W(21)
  ) u_mc (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clr(rst_int),
    .mc_state(mc_state),
    .mc_tick(mc_tick),
    .div_out(div_out)
  );

  // All reset causes merged into one stretched level
  reset_combiner #(
    .HOLD(`RST_HOLD_CYC)
  ) u_rst (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .reset_pin_n(reset_pin_n),
    .cause_pulse({guard_hit, wdt_reset, trap_hit}),
    .rst_int(rst_int),
    .pin_low(pin_low)
  );

  // Trap check; a software trap looks one address ahead
  always_comb
  begin
    chk_addr = swi_exec ? fetch_addr + 20'h0_0001 : fetch_addr;
    trap_hit = 1'b0;
    if (fetch_valid && core_run)
    begin
      // Special function space below RAM always traps
      if (chk_addr < RAM_LO)
        trap_hit = 1'b1;
      // RAM only while trapping is permitted
      else if (chk_addr <= RAM_HI && s_r.trap_allowed)
        trap_hit = 1'b1;
      // Data buffer space always traps
      else if (chk_addr >= DBR_LO && chk_addr <= DBR_HI)
        trap_hit = 1'b1;
    end
  end

  // Clock guard: a write that would stop the clock resets instead
  assign guard_hit = s_r.aw_v && s_r.w_v && !s_r.bvalid && s_r.w_s[0]
    && s_r.aw_a == `OFF_SYSCTL2
    && (!s_r.w_d[`SYS2_GUARD_BIT] || s_r.w_d[`SYS2_ZERO_BIT]);

  // Source 0 is the watchdog interrupt, pseudo non-maskable
  assign en_eff = s_r.en | N_SRC'(1);
  assign wake_set = s_r.pend & en_eff;

  // Next state: bus, sleep control, acceptance, reset
  always_comb
  begin
    logic [31:0] wd;
    logic acc_done;
    logic [N_SRC-1:0] clr_mask;
    wd = 32'h0000_0000;
    acc_done = 1'b0;
    clr_mask = '0;
    s_nxt = s_r;
    s_nxt.accept = 1'b0;
    s_nxt.resume = 1'b0;
    // Response handshakes retire
    if (s_r.bvalid && s_axi_bready)
      s_nxt.bvalid = 1'b0;
    if (s_r.rvalid && s_axi_rready)
      s_nxt.rvalid = 1'b0;
    // Address and data taken in either order
    if (!s_r.aw_v && s_axi_awvalid)
    begin
      s_nxt.aw_v = 1'b1;
      s_nxt.aw_a = s_axi_awaddr;
    end
    if (!s_r.w_v && s_axi_wvalid)
    begin
      s_nxt.w_v = 1'b1;
      s_nxt.w_d = s_axi_wdata;
      s_nxt.w_s = s_axi_wstrb;
    end
    // Read answered one cycle after the address
    if (!s_r.rvalid && s_axi_arvalid)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = idle_reset_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        `OFF_SYSCTL2:
          s_nxt.rdata = {24'h00_0000, s_r.sys2[7:4], 4'h0};
        // Trap control and key read back nothing
        `OFF_TRAP_ALLOW, `OFF_TRAP_KEY:
          s_nxt.rdata = 32'h0000_0000;
        `OFF_CORE:
          s_nxt.rdata = {24'h00_0000, s_r.core};
        `OFF_ENABLE:
          s_nxt.rdata = 32'(s_r.en);
        `OFF_PEND:
          s_nxt.rdata = 32'(s_r.pend);
        `OFF_CAUSE:
          s_nxt.rdata = {28'h000_0000, s_r.cause};
        `OFF_STATUS:
          s_nxt.rdata = {30'h0000_0000, s_r.trap_allowed,
                         s_r.mode == idle_reset_pkg::MODE_IDLE};
        default:
        begin
          // Unmapped address
          s_nxt.rdata = 32'h0000_0000;
          s_nxt.rresp = idle_reset_pkg::RESP_DECERR;
        end
      endcase
    end
    // Sleep entry takes effect at a machine cycle boundary
    if (s_r.idle_req && mc_tick)
    begin
      s_nxt.idle_req = 1'b0;
      // A watchdog interrupt in flight wins over sleep
      if (!(s_r.pend[0] || irq_request[0]))
        s_nxt.mode = idle_reset_pkg::MODE_IDLE;
    end
    // Wake from sleep on any enabled pending source
    if (s_r.mode == idle_reset_pkg::MODE_IDLE && (|wake_set))
    begin
      s_nxt.mode = idle_reset_pkg::MODE_RUN;
      // Master off: plain resume, latch left for software
      if (!s_r.core[`CORE_MIE_BIT] && !wake_set[0])
        s_nxt.resume = 1'b1;
    end
    // Acceptance in run mode, lowest index has priority
    else if (s_r.mode == idle_reset_pkg::MODE_RUN && mc_tick)
    begin
      for (int i = 0; i < N_SRC; i++)
      begin
        if (!acc_done && wake_set[i]
            && (s_r.core[`CORE_MIE_BIT] || i == 0))
        begin
          acc_done = 1'b1;
          s_nxt.accept = 1'b1;
          s_nxt.accept_id = 5'(i);
          clr_mask[i] = 1'b1;
        end
      end
      if (acc_done)
      begin
        // Handler runs with master off and nesting noted
        s_nxt.core[`CORE_MIE_BIT] = 1'b0;
        s_nxt.core[`CORE_NEST_BIT] = 1'b1;
      end
    end
    s_nxt.pend = s_r.pend & ~clr_mask;
    // Register write once both halves are held
    if (s_r.aw_v && s_r.w_v && !s_r.bvalid)
    begin
      s_nxt.aw_v = 1'b0;
      s_nxt.w_v = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = idle_reset_pkg::RESP_OKAY;
      unique case (s_r.aw_a)
        `OFF_SYSCTL2:
        begin
          wd = merge({24'h00_0000, s_r.sys2}, s_r.w_d, s_r.w_s);
          s_nxt.sys2 = {wd[7:4], 4'h0};
          // Sleep request only from a legal write
          if (!guard_hit && wd[`SYS2_IDLE_BIT])
            s_nxt.idle_req = 1'b1;
        end
        `OFF_TRAP_ALLOW:
        begin
          // Changes only on the first write here after the key was written
          if (s_r.key_armed && s_r.w_s[0])
            s_nxt.trap_allowed = s_r.w_d[0];
          s_nxt.key_armed = 1'b0;
        end
        `OFF_TRAP_KEY:
          s_nxt.key_armed = s_r.w_s[0]
            && s_r.w_d[7:0] == `TRAP_KEY_VAL;
        `OFF_CORE:
        begin
          wd = merge({24'h00_0000, s_r.core}, s_r.w_d, s_r.w_s);
          s_nxt.core = wd[7:0];
        end
        `OFF_ENABLE:
        begin
          wd = merge(32'(s_r.en), s_r.w_d, s_r.w_s);
          s_nxt.en = wd[N_SRC-1:0];
        end
        `OFF_PEND:
        begin
          // Plain store; the waking latch is cleared this way
          wd = merge(32'(s_r.pend), s_r.w_d, s_r.w_s);
          s_nxt.pend = wd[N_SRC-1:0] & ~clr_mask;
        end
        `OFF_CAUSE:
          // Write one to clear a cause bit
          if (s_r.w_s[0])
            s_nxt.cause = s_r.cause & ~s_r.w_d[3:0];
        `OFF_STATUS:
          s_nxt.bresp = idle_reset_pkg::RESP_OKAY;
        default:
          s_nxt.bresp = idle_reset_pkg::RESP_DECERR;
      endcase
    end
    // New requests win over accept and write clears in the same cycle
    s_nxt.pend = s_nxt.pend | irq_request;
    // Cause flags are sticky; internal reset does not clear them
    s_nxt.cause = s_nxt.cause | {guard_hit, wdt_reset, trap_hit,
                                 pin_low};
    // Internal reset: defined core state, others left alone
    if (rst_int)
    begin
      s_nxt.mode = idle_reset_pkg::MODE_RUN;
      s_nxt.idle_req = 1'b0;
      s_nxt.sys2 = `SYS2_RESET_VAL;
      s_nxt.core[`CORE_BANK_LSB +: `CORE_BANK_W] = 4'h0;
      s_nxt.core[`CORE_MIE_BIT] = 1'b0;
      s_nxt.core[`CORE_NEST_BIT] = 1'b0;
      s_nxt.core[`CORE_JF_BIT] = 1'b1;
      s_nxt.core[`CORE_WDTEN_BIT] = 1'b1;
      s_nxt.en = '0;
      s_nxt.pend = '0;
      s_nxt.trap_allowed = 1'b1;
      s_nxt.key_armed = 1'b0;
      s_nxt.accept = 1'b0;
      s_nxt.resume = 1'b0;
    end
    // Vector fetch on the cycle after release
    s_nxt.rst_d = rst_int;
    s_nxt.vec = s_r.rst_d && !rst_int;
  end

  // State register; resetn loads every field, core state also reset via rst_int
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_r <= '0;
      s_r.mode <= idle_reset_pkg::MODE_RUN;
      s_r.sys2 <= `SYS2_RESET_VAL;
      s_r.core <= 8'hC0;
      s_r.trap_allowed <= 1'b1;
      s_r.rst_d <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Handshake readies are combinational
  assign s_axi_awready = !s_r.aw_v;
  assign s_axi_wready = !s_r.w_v;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;

  // Core side outputs; sleep halts core and watchdog only
  assign core_reset_n = !rst_int;
  assign core_run = !rst_int
    && s_r.mode == idle_reset_pkg::MODE_RUN;
  assign periph_run = !rst_int;
  assign wdt_run = core_run && s_r.core[`CORE_WDTEN_BIT];
  assign irq_accept = s_r.accept;
  assign irq_accept_id = s_r.accept_id;
  assign wake_resume = s_r.resume;
  assign vector_fetch = s_r.vec;
  assign vector_addr = `RESET_VECTOR;
  assign bank_selector = s_r.core[`CORE_BANK_LSB +: `CORE_BANK_W];
  assign master_irq_enable = s_r.core[`CORE_MIE_BIT];
  assign nesting_flag = s_r.core[`CORE_NEST_BIT];
  assign jump_status_flag = s_r.core[`CORE_JF_BIT];

endmodule

// File: idle_release_and_reset_gen_tb.sv
// Testbench of the sleep release and reset generator
`timescale 1ns/100ps
`include "idle_reset_regs.svh"
module idle_release_and_reset_gen_tb;
  logic ref_clk, resetn, pin_go, reset_pin_n;
  logic [7:0] irq_go, irq_request, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, bank_selector;
  logic [1:0] s_axi_bresp, s_axi_rresp, mc_state;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, fetch_valid, swi_exec, wdt_reset;
  logic [19:0] fetch_addr, vector_addr;
  logic core_reset_n, core_run, periph_run, wdt_run, irq_accept;
  logic wake_resume, vector_fetch, master_irq_enable, nesting_flag;
  logic jump_status_flag, seen_rst, seen_acc, seen_res;
  logic [4:0] irq_accept_id, seen_id;
  logic [20:0] div_out;
  int mismatches = 0; // Failed comparisons
  int samples_checked = 0; // Comparisons made
  int cyc = 0; // Cycles since start
  idle_release_and_reset_gen uut (.*);
  pin_irq_model u_model (.ref_clk, .pin_go, .irq_go, .reset_pin_n,
    .irq_request);
  // 20 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = !ref_clk;
  end
  // Hang guard
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      mismatches++;
      summarize();
    end
  end
  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Compare and count
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bus write; each channel held until its own ready
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] eb = 2'h0);
    logic aw_ok, w_ok;
    {aw_ok, w_ok} = 2'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge ref_clk);
      aw_ok |= s_axi_awvalid && s_axi_awready;
      w_ok |= s_axi_wvalid && s_axi_wready;
      s_axi_awvalid <= !aw_ok;
      s_axi_wvalid <= !w_ok;
    end
    do @(posedge ref_clk); while (!s_axi_bvalid);
    check("bresp", 32'(s_axi_bresp), 32'(eb));
  endtask
  // Bus read and compare of data and response
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    check("rdata", s_axi_rdata, exp);
    check("rresp", 32'(s_axi_rresp), 32'(er));
  endtask
  // Hold an interrupt request pattern for n cycles
  task automatic pulse(input logic [7:0] v, input int n);
    irq_go <= v;
    repeat (n) @(posedge ref_clk);
    irq_go <= 8'h00;
  endtask
  // Note resets, accepts and resumes over n cycles
  task automatic watch(input int n);
    {seen_rst, seen_acc, seen_res} = 3'h0;
    repeat (n)
    begin
      @(posedge ref_clk);
      seen_rst |= !core_reset_n;
      seen_res |= wake_resume;
      seen_acc |= irq_accept;
      if (irq_accept) seen_id = irq_accept_id;
    end
  endtask
  // Wait out an internal reset
  task automatic wait_rel();
    while (!core_reset_n) @(posedge ref_clk);
  endtask
  // Read the cause bits, then clear them
  task automatic cause_chk(input logic [31:0] exp);
    rd_chk(`OFF_CAUSE, exp, 2'h0);
    axi_wr(`OFF_CAUSE, 32'h0000_000F);
  endtask
  // One fetch or software trap, reset expected or not
  task automatic trap_try(input logic [19:0] a, input logic sw,
                          input logic er);
    fetch_addr <= a;
    fetch_valid <= 1'b1;
    swi_exec <= sw;
    @(posedge ref_clk);
    fetch_valid <= 1'b0;
    swi_exec <= 1'b0;
    watch(6);
    check("trap", 32'(seen_rst), 32'(er));
    wait_rel();
  endtask
  // Enter sleep and confirm it
  task automatic sleep();
    axi_wr(`OFF_SYSCTL2, 32'h0000_0090);
    repeat (5) @(posedge ref_clk);
    rd_chk(`OFF_STATUS, 32'h0000_0003, 2'h0);
  endtask
  // Main sequence
  initial
  begin
    resetn = 1'b0;
    {pin_go, fetch_valid, swi_exec, wdt_reset} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_bready, s_axi_rready} = 2'h0;
    {irq_go, s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 28'h000_0000;
    {s_axi_wdata, fetch_addr} = 52'h0_0000_0000_0000;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    wait_rel();
    rd_chk(`OFF_CORE, 32'h0000_00C0, 2'h0);
    rd_chk(`OFF_SYSCTL2, 32'h0000_0080, 2'h0);
    rd_chk(`OFF_TRAP_ALLOW, 32'h0000_0000, 2'h0);
    rd_chk(`OFF_STATUS, 32'h0000_0002, 2'h0);
    rd_chk(8'h40, 32'h0000_0000, 2'h3);
    axi_wr(8'h40, 32'h0000_0000, 2'h3);
    axi_wr(`OFF_ENABLE, 32'h0000_0008);
    sleep();
    check("run", 32'({core_run, periph_run, wdt_run}), 32'h2);
    pulse(8'h08, 1);
    watch(20);
    check("resume", 32'({seen_res, seen_acc}), 32'h2);
    rd_chk(`OFF_PEND, 32'h0000_0008, 2'h0);
    axi_wr(`OFF_PEND, 32'h0000_0000);
    rd_chk(`OFF_PEND, 32'h0000_0000, 2'h0);
    axi_wr(`OFF_CORE, 32'h0000_00D0);
    sleep();
    pulse(8'h08, 1);
    watch(20);
    check("accept", 32'({seen_acc, seen_id}), 32'h23);
    rd_chk(`OFF_PEND, 32'h0000_0000, 2'h0);
    rd_chk(`OFF_CORE, 32'h0000_00E0, 2'h0);
    rd_chk(`OFF_STATUS, 32'h0000_0002, 2'h0);
    fork
      axi_wr(`OFF_SYSCTL2, 32'h0000_0090);
      pulse(8'h01, 10);
      watch(12);
    join
    check("wdt_irq", 32'({seen_acc, seen_id}), 32'h20);
    rd_chk(`OFF_STATUS, 32'h0000_0002, 2'h0);
    sleep();
    pin_go <= 1'b1;
    @(posedge ref_clk);
    pin_go <= 1'b0;
    watch(20);
    check("pin_rst", 32'(seen_rst), 32'h1);
    wait_rel();
    rd_chk(`OFF_STATUS, 32'h0000_0002, 2'h0);
    rd_chk(`OFF_CORE, 32'h0000_00C0, 2'h0);
    cause_chk(32'h0000_0001);
    trap_try(20'h0_0040, 1'b0, 1'b1);
    cause_chk(32'h0000_0002);
    axi_wr(`OFF_TRAP_ALLOW, 32'h0000_0000);
    rd_chk(`OFF_STATUS, 32'h0000_0002, 2'h0);
    axi_wr(`OFF_TRAP_KEY, 32'(`TRAP_KEY_VAL));
    axi_wr(`OFF_TRAP_ALLOW, 32'h0000_0000);
    rd_chk(`OFF_STATUS, 32'h0000_0000, 2'h0);
    trap_try(20'h0_0100, 1'b0, 1'b0);
    trap_try(20'h0_0F00, 1'b0, 1'b1);
    axi_wr(`OFF_TRAP_KEY, 32'(`TRAP_KEY_VAL));
    axi_wr(`OFF_TRAP_ALLOW, 32'h0000_0000);
    trap_try(20'h0_0EFF, 1'b1, 1'b1);
    rd_chk(`OFF_STATUS, 32'h0000_0002, 2'h0);
    cause_chk(32'h0000_0002);
    wdt_reset <= 1'b1;
    @(posedge ref_clk);
    wdt_reset <= 1'b0;
    watch(6);
    check("wdt_rst", 32'(seen_rst), 32'h1);
    wait_rel();
    cause_chk(32'h0000_0004);
    for (int i = 0; i < 2; i++)
    begin
      axi_wr(`OFF_SYSCTL2, i ? 32'h0000_00A0 : 32'h0000_0000);
      watch(6);
      check("clk_rst", 32'(seen_rst), 32'h1);
      wait_rel();
      cause_chk(32'h0000_0008);
    end
    rd_chk(`OFF_CAUSE, 32'h0000_0000, 2'h0);
    summarize();
  end
endmodule

// File: idle_reset_pkg.sv
// Types shared by the sleep release and reset generator
package idle_reset_pkg;

  // Core operating mode
  typedef enum logic {MODE_RUN, MODE_IDLE} mode_type;

  // AXI response codes
  typedef enum logic [1:0] {
    RESP_OKAY = 2'b00,
    RESP_SLVERR = 2'b10,
    RESP_DECERR = 2'b11
  } resp_type;

endpackage

// File: idle_reset_regs.svh
// Offsets, field positions, reset values and timing counts of the block
`ifndef IDLE_RESET_REGS_SVH
`define IDLE_RESET_REGS_SVH

// Register byte offsets on the AXI4-Lite slave
`define OFF_SYSCTL2 8'h00
`define OFF_TRAP_ALLOW 8'h04
`define OFF_TRAP_KEY 8'h08
`define OFF_CORE 8'h0C
`define OFF_ENABLE 8'h10
`define OFF_PEND 8'h14
`define OFF_CAUSE 8'h18
`define OFF_STATUS 8'h1C

// Second system control register fields
`define SYS2_GUARD_BIT 7
`define SYS2_ZERO_BIT 5
`define SYS2_IDLE_BIT 4
`define SYS2_RESET_VAL 8'h80

// Core flag register fields
`define CORE_BANK_LSB 0
`define CORE_BANK_W 4
`define CORE_MIE_BIT 4
`define CORE_NEST_BIT 5
`define CORE_JF_BIT 6
`define CORE_WDTEN_BIT 7

// Reset cause bits
`define CAUSE_PIN 0
`define CAUSE_TRAP 1
`define CAUSE_WDT 2
`define CAUSE_CLK 3

// Trap unlock key, value is arbitrary
`define TRAP_KEY_VAL 8'hA5

// Reset vector location
`define RESET_VECTOR 20'hF_FFFC

// Timing: clocks, machine cycle, internal reset hold time
`define REF_CLK_HZ 20000000
`define OSC_HZ 20000000
`define MC_STATES 4
`define RST_HOLD_FC 12
`define RST_HOLD_CYC ((`RST_HOLD_FC * `REF_CLK_HZ + `OSC_HZ - 1) / `OSC_HZ)

`endif

// File: idle_reset_sva.sv
// Port checks of the sleep release and reset generator
`timescale 1ns/100ps
`include "idle_reset_regs.svh"
module idle_reset_sva (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic reset_pin_n,
  input wire logic wdt_reset,
  input wire logic core_reset_n,
  input wire logic core_run,
  input wire logic periph_run,
  input wire logic wdt_run,
  input wire logic irq_accept,
  input wire logic wake_resume,
  input wire logic vector_fetch,
  input wire logic [19:0] vector_addr,
  input wire logic [3:0] bank_selector,
  input wire logic master_irq_enable,
  input wire logic nesting_flag,
  input wire logic jump_status_flag,
  input wire logic [1:0] mc_state,
  input wire logic [20:0] div_out
);
  // All checks on the one clock, quiet in power-on reset
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Start address fetch follows the release
  property p_vector;
    $rose(core_reset_n) |=> vector_fetch && vector_addr == `RESET_VECTOR;
  endproperty
  a_vector: assert property (p_vector) else $error("no vector fetch");
  // Flags held at their reset values in reset
  property p_flags;
    !core_reset_n && !$past(core_reset_n) |-> bank_selector == 4'h0 &&
      !master_irq_enable && !nesting_flag && jump_status_flag;
  endproperty
  a_flags: assert property (p_flags) else $error("flags not reset");
  // Divider cleared in reset
  property p_div;
    !core_reset_n && !$past(core_reset_n) |-> div_out == 21'h00_0000;
  endproperty
  a_div: assert property (p_div) else $error("divider not clear");
  // Four states per machine cycle, one per clock
  property p_mc;
    core_reset_n && $past(core_reset_n) |->
      mc_state == 2'($past(mc_state) + 2'h1);
  endproperty
  a_mc: assert property (p_mc) else $error("state count wrong");
  // Watchdog only runs with the core
  property p_wdt_stop;
    wdt_run |-> core_run && core_reset_n;
  endproperty
  a_wdt_stop: assert property (p_wdt_stop) else $error("wdt runs");
  // Peripherals keep running outside reset
  property p_periph;
    core_reset_n |-> periph_run;
  endproperty
  a_periph: assert property (p_periph) else $error("periph stopped");
  // Pin held low gives internal reset
  property p_pin;
    !reset_pin_n [*5] |-> !core_reset_n && !core_run;
  endproperty
  a_pin: assert property (p_pin) else $error("pin reset missing");
  // Watchdog reset reaches the core promptly
  property p_wdt;
    wdt_reset |-> ##[1:3] !core_reset_n;
  endproperty
  a_wdt: assert property (p_wdt) else $error("wdt reset missing");
  // Internal reset is stretched
  property p_hold;
    $fell(core_reset_n) |-> !core_reset_n [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("reset too short");
  // Accept clears master enable and sets nesting
  property p_accept;
    irq_accept |-> !master_irq_enable && nesting_flag;
  endproperty
  a_accept: assert property (p_accept) else $error("accept flags");
  // Resume without vector only with master enable off
  property p_resume;
    wake_resume |-> !master_irq_enable && !irq_accept;
  endproperty
  a_resume: assert property (p_resume) else $error("bad resume");
endmodule
bind idle_release_and_reset_gen idle_reset_sva u_sva (.*);

// File: machine_cycle_gen.sv
// Machine cycle state counter, prescaler and divider chain
`timescale 1ns/100ps
`include "idle_reset_regs.svh"
module machine_cycle_gen #(
  parameter int PRE_W = 3,
  parameter int DIV_W = 21
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clr,
  output logic [1:0] mc_state,
  output logic mc_tick,
  output logic [DIV_W-1:0] div_out
);

  // All state of the divider in one word
  typedef struct packed {
    logic [1:0] st;
    logic [PRE_W-1:0] pre;
    logic [DIV_W-1:0] div;
    logic tick;
  } mc_type;

  mc_type s_r;
  mc_type s_nxt;

  // Four states per machine cycle, divider steps on prescaler wrap
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (clr)
    begin
      s_nxt = '0;
    end
    else
    begin
      s_nxt.st = s_r.st + 2'd1;
      s_nxt.tick = (s_r.st == 2'(`MC_STATES - 2));
      s_nxt.pre = s_r.pre + PRE_W'(1);
      if (&s_r.pre)
      begin
        s_nxt.div = s_r.div + DIV_W'(1);
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign mc_state = s_r.st;
  assign mc_tick = s_r.tick;
  assign div_out = s_r.div;

endmodule

// File: pin_irq_model.sv
// Model of the external reset driver and the interrupt sources
`timescale 1ns/100ps
module pin_irq_model (
  input wire logic ref_clk,
  input wire logic pin_go,
  input wire logic [7:0] irq_go,
  output logic reset_pin_n,
  output logic [7:0] irq_request
);
  int low_cnt = 0; // Pin low cycles still owed
  assign reset_pin_n = (low_cnt == 0);
  // Pin low well past three machine cycles, then pulled up
  always @(posedge ref_clk)
  begin
    low_cnt <= pin_go ? 16 : low_cnt - int'(low_cnt > 0);
    irq_request <= irq_go; // One request per cycle of irq_go
  end
endmodule

// File: reset_combiner.sv
// Combines reset causes into one stretched internal reset
`timescale 1ns/100ps
`include "idle_reset_regs.svh"
module reset_combiner #(
  parameter int HOLD = `RST_HOLD_CYC
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic reset_pin_n,
  input wire logic [2:0] cause_pulse,
  output logic rst_int,
  output logic pin_low
);

  // Synchroniser pair, hold counter and output level
  typedef struct packed {
    logic meta;
    logic pin;
    logic [7:0] cnt;
    logic rst;
  } comb_type;

  comb_type s_r;
  comb_type s_nxt;

  // Any cause restarts the hold; release only once all are gone
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.meta = reset_pin_n;
    s_nxt.pin = s_r.meta;
    if (!s_r.pin || (|cause_pulse))
      s_nxt.cnt = 8'(HOLD);
    else if (s_r.cnt != 8'h00)
      s_nxt.cnt = s_r.cnt - 8'h01;
    s_nxt.rst = !s_r.pin || (|cause_pulse) || (s_r.cnt > 8'h01);
  end

  // Reset asserted from power-on until the pin has been seen high and the hold count has run out
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      s_r <= '{meta: 1'b0, pin: 1'b0, cnt: 8'h00, rst: 1'b1};
    else
      s_r <= s_nxt;
  end

  assign rst_int = s_r.rst;
  assign pin_low = !s_r.pin;

endmodule
